// file: src/cmpl_flag_bank.sv
// Bank of sticky flags set by hardware, cleared by software write-one-to-clear.
// Assumes set and clear vectors are synchronous to aclk; set wins over clear.
`default_nettype none
module cmpl_flag_bank
  import dma_cmpl_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Set and clear
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic [WIDTH-1:0] clr_vec,
  // Flag state
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // Per bit: event arriving with a clear is kept
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        flags_nxt[gi] = set_vec[gi] | (flags_r[gi] & ~clr_vec[gi]);
      end
    end
  endgenerate

  // Register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= FLAGS_RESET[WIDTH-1:0];
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule : cmpl_flag_bank
`default_nettype wire

// file: src/dma_cmpl_pkg.sv
// Package for the completion signaling block: register map, settings word fields, types.
// Assumes a single 50 MHz clock domain and an AXI4-Lite register bus with 32-bit data.
`default_nettype none
package dma_cmpl_pkg;

  // Register byte offsets
  localparam logic [7:0] SETTINGS_OFF = 8'h00;
  localparam logic [7:0] CHAIN_FLAGS_OFF = 8'h04;
  localparam logic [7:0] CHAIN_CLR_OFF = 8'h08;
  localparam logic [7:0] PEND_FLAGS_OFF = 8'h0C;
  localparam logic [7:0] PEND_CLR_OFF = 8'h10;
  localparam logic [7:0] IRQ_EN_OFF = 8'h14;
  localparam logic [7:0] STATUS_OFF = 8'h18;

  // Settings word field positions
  localparam int PRIV_LSB = 24;
  localparam int MID_CHAIN_BIT = 23;
  localparam int FINAL_CHAIN_BIT = 22;
  localparam int MID_INT_BIT = 21;
  localparam int FINAL_INT_BIT = 20;
  localparam int RSVD_WR0_BIT = 19;
  localparam int CODE_LSB = 12;
  localparam int CPS_BIT = 11;

  // Writable bits of the settings word: 23..19, 17..0
  localparam logic [31:0] SETTINGS_WMASK = 32'h00FB_FFFF;
  localparam logic [31:0] SETTINGS_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Completion event from the channel's move request engine
  typedef struct packed {
    logic submitted;  // request handed to the transfer controller
    logic moved;      // request's data finished moving
    logic is_final;   // request is the descriptor's last
  } cmpl_event_type;

  // Decoded settings fields
  typedef struct packed {
    logic mid_chain_enable;
    logic final_chain_enable;
    logic mid_interrupt_enable;
    logic final_interrupt_enable;
    logic [5:0] completion_code;
    logic completion_point_select;
  } settings_type;

endpackage : dma_cmpl_pkg
`default_nettype wire

// file: src/dma_completion_signaling.sv
// Completion signaling for one DMA channel: settings word, chained event and
// interrupt pending flags, interrupt enables and the CPU interrupt line.
// Assumes AXI4-Lite from software, descriptor write strobes and completion
// events from the channel controller, all on aclk.
`default_nettype none
module dma_completion_signaling
  import dma_cmpl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Descriptor write notice from the store
  input wire logic desc_write,
  input wire logic [3:0] desc_writer_priv,
  // Move request completion events
  input wire cmpl_event_type cmpl_event,
  // CPU interrupt
  output logic cpu_irq
);

  // Write channel state
  logic aw_held_r, aw_held_nxt;
  logic w_held_r, w_held_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  // Read channel state
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // Registers
  logic [31:0] settings_r, settings_nxt;
  logic [31:0] irq_en_r, irq_en_nxt;
  logic [31:0] chain_flags;
  logic [31:0] pend_flags;
  logic [31:0] chain_set, chain_clr;
  logic [31:0] pend_set, pend_clr;
  logic code_err_r, code_err_nxt;
  logic irq_r, irq_nxt;
  // Helpers
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] wdata_masked;
  settings_type cfg;
  logic done;
  logic code_valid;

  // Field view of the settings word
  // Lower settings fields belong to the transfer side and are ignored here
  always_comb begin
    cfg.mid_chain_enable = settings_r[MID_CHAIN_BIT];
    cfg.final_chain_enable = settings_r[FINAL_CHAIN_BIT];
    cfg.mid_interrupt_enable = settings_r[MID_INT_BIT];
    cfg.final_interrupt_enable = settings_r[FINAL_INT_BIT];
    cfg.completion_code = settings_r[CODE_LSB+5:CODE_LSB];
    cfg.completion_point_select = settings_r[CPS_BIT];
  end

  // Completion point: submit when early, else after data moved
  assign done = cfg.completion_point_select ? cmpl_event.submitted : cmpl_event.moved;
  // Reserved codes 20h..3Fh map to no flag
  assign code_valid = (cfg.completion_code[5] == 1'b0);

  // Flag set vectors; one-hot at the completion code
  always_comb begin
    chain_set = 32'h0000_0000;
    pend_set = 32'h0000_0000;
    if (done && code_valid) begin
      if ((cmpl_event.is_final && cfg.final_chain_enable) ||
          (!cmpl_event.is_final && cfg.mid_chain_enable)) begin
        chain_set[cfg.completion_code[4:0]] = 1'b1;
      end
      if ((cmpl_event.is_final && cfg.final_interrupt_enable) ||
          (!cmpl_event.is_final && cfg.mid_interrupt_enable)) begin
        pend_set[cfg.completion_code[4:0]] = 1'b1;
      end
    end
  end

  // Byte-lane mask from write strobes
  genvar bi;
  generate
    for (bi = 0; bi < 4; bi++) begin : g_lane
      assign wmask[bi*8 +: 8] = {8{wstrb_r[bi]}};
    end
  endgenerate

  // Commit once both beats are held and no response is still waiting;
  // holding back on bvalid keeps a second write from overtaking the first
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wdata_masked = wdata_r & wmask;

  // Write-one-to-clear vectors
  always_comb begin
    chain_clr = 32'h0000_0000;
    pend_clr = 32'h0000_0000;
    if (do_write && awaddr_r == CHAIN_CLR_OFF) begin
      chain_clr = wdata_masked;
    end
    if (do_write && awaddr_r == PEND_CLR_OFF) begin
      pend_clr = wdata_masked;
    end
  end

  // Chained event flags: set by completions, cleared by software
  cmpl_flag_bank #(
    .WIDTH(32)
  ) u_chain_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_vec(chain_set),
    .clr_vec(chain_clr),
    .flags(chain_flags)
  );

  // Interrupt pending flags; a set beats a clear in the same cycle
  cmpl_flag_bank #(
    .WIDTH(32)
  ) u_pend_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_vec(pend_set),
    .clr_vec(pend_clr),
    .flags(pend_flags)
  );

  // Write channel: address and data taken in either order
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      case (awaddr_r)
        SETTINGS_OFF, CHAIN_CLR_OFF, PEND_CLR_OFF, IRQ_EN_OFF: bresp_nxt = RESP_OKAY;
        CHAIN_FLAGS_OFF, PEND_FLAGS_OFF, STATUS_OFF: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // Register updates; reserved settings bits other than bit 19 never stored
  always_comb begin
    settings_nxt = settings_r;
    irq_en_nxt = irq_en_r;
    if (do_write && awaddr_r == SETTINGS_OFF) begin
      // Bit 19 is stored as written; software keeps it zero.
      settings_nxt = (settings_r & ~(wmask & SETTINGS_WMASK)) |
                     (wdata_r & wmask & SETTINGS_WMASK);
    end
    if (do_write && awaddr_r == IRQ_EN_OFF) begin
      irq_en_nxt = (irq_en_r & ~wmask) | wdata_masked;
    end
    // Any descriptor word written stamps the writer's tag
    if (desc_write) begin
      settings_nxt[PRIV_LSB+3:PRIV_LSB] = desc_writer_priv;
    end
  end

  // Sticky note that a reserved code met a completion
  // A completion in the clearing cycle keeps the note set
  always_comb begin
    code_err_nxt = code_err_r;
    if (done && !code_valid) begin
      code_err_nxt = 1'b1;
    end else if (do_write && awaddr_r == STATUS_OFF && wdata_masked[0]) begin
      code_err_nxt = 1'b0;
    end
  end

  // Pending flag only reaches the CPU through its enable
  assign irq_nxt = |(pend_flags & irq_en_r);

  // Read channel: one read at a time, answered the cycle after arvalid
  // Data is sampled at the taking edge, so a flag set then shows next read
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        SETTINGS_OFF: rdata_nxt = settings_r & (SETTINGS_WMASK | 32'h0F00_0000);
        CHAIN_FLAGS_OFF: rdata_nxt = chain_flags;
        PEND_FLAGS_OFF: rdata_nxt = pend_flags;
        IRQ_EN_OFF: rdata_nxt = irq_en_r;
        STATUS_OFF: rdata_nxt = {30'h0000_0000, irq_r, code_err_r};
        CHAIN_CLR_OFF, PEND_CLR_OFF: rdata_nxt = 32'h0000_0000;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      settings_r <= SETTINGS_RESET;
      irq_en_r <= FLAGS_RESET;
      code_err_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      settings_r <= settings_nxt;
      irq_en_r <= irq_en_nxt;
      code_err_r <= code_err_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Handshake outputs; a held beat blocks its channel until the response
  // Ready depends on state only, never on valid, so no combinational loop
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign cpu_irq = irq_r;

endmodule : dma_completion_signaling
`default_nettype wire

// file: tb/dma_completion_signaling_props.sv
// Checker for the completion signaling block: bus handshakes and interrupt line.
// Assumes it is bound to the top module's ports; one clock, synchronous reset.
`default_nettype none
module dma_completion_signaling_props
  import dma_cmpl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events and interrupt
  input wire cmpl_event_type cmpl_event,
  input wire logic cpu_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both write beats taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write ready while response pending");
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read ready while data pending");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_r_answer;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_b_answer;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  // Offsets above 18h refuse with an error code and zero data
  property p_unmapped;
    s_rd_taken and (s_axi_araddr > 8'h18) |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  // The line rises only after an event or a register write
  property p_irq_cause;
    $rose(cpu_irq) |-> $past(s_axi_bvalid) || $past(cmpl_event != 3'b000, 2) || $past(cmpl_event != 3'b000, 3);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
  // Only software writes can withdraw the line
  property p_irq_stays;
    cpu_irq && !s_axi_bvalid |=> cpu_irq;
  endproperty
  a_irq_stays: assert property (p_irq_stays) else $error("interrupt dropped by itself");
endmodule : dma_completion_signaling_props
bind dma_completion_signaling dma_completion_signaling_props i_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cmpl_event(cmpl_event), .cpu_irq(cpu_irq));
`default_nettype wire

// file: tb/dma_completion_signaling_test.sv
// Testbench for the completion signaling block: bus tasks and scenarios.
// Assumes the package, the design and its checker are compiled first.
`default_nettype none
module dma_completion_signaling_test
  import dma_cmpl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, dw, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] wr_resp, rd_resp;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic [3:0] dwp;
  cmpl_event_type ev;
  int fail_count = 0;
  int num_checks = 0;

  dma_completion_signaling i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .desc_write(dw), .desc_writer_priv(dwp), .cmpl_event(ev), .cpu_irq(irq));

  // Free-running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  // Both beats offered together, each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    wr_resp = bresp;
    br <= 1'b0;
  endtask : axi_write

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd_resp = rresp;
    rr <= 1'b0;
    check_word(what, exp, rd);
  endtask : rd_chk

  // One-cycle event, then time for flags and the line to settle
  task automatic pulse(input cmpl_event_type e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= 3'b000;
    repeat (3) @(posedge aclk);
  endtask : pulse

  task automatic t_settings();
    rd_chk(SETTINGS_OFF, 32'h0000_0000, "settings reset");
    check_word("settings read resp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, rd_resp});
    // Every bit but the reserved write-zero bit set
    axi_write(SETTINGS_OFF, 32'hFFF7_FFFF);
    check_word("settings write resp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, wr_resp});
    rd_chk(SETTINGS_OFF, 32'h00F3_FFFF, "settings mask");
    rd_chk(8'h40, 32'h0000_0000, "unmapped");
    check_word("unmapped read resp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, rd_resp});
    axi_write(8'h40, 32'hFFFF_FFFF);
    check_word("unmapped write resp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, wr_resp});
    // Only the second byte lane may land
    ws <= 4'h2;
    axi_write(IRQ_EN_OFF, 32'hFFFF_FFFF);
    ws <= 4'hF;
    rd_chk(IRQ_EN_OFF, 32'h0000_FF00, "strobe lanes");
    axi_write(IRQ_EN_OFF, 32'h0000_0000);
  endtask : t_settings

  // Back-to-back descriptor writes, last writer wins
  task automatic t_priv();
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      dw <= 1'b1;
      dwp <= i ? 4'h5 : 4'hA;
    end
    @(posedge aclk);
    dw <= 1'b0;
    rd_chk(SETTINGS_OFF, 32'h05F3_FFFF, "priv tag");
  endtask : t_priv

  // Every enable against mid and final completions
  task automatic t_flags();
    logic [31:0] e;
    for (int i = 0; i < 4; i++) begin
      for (int f = 0; f < 2; f++) begin
        e = 32'h1 << (31 - i * 9);
        axi_write(SETTINGS_OFF, (32'h0080_0000 >> i) | (32'(31 - i * 9) << 12));
        pulse({2'b01, f[0]});
        rd_chk(CHAIN_FLAGS_OFF, ((i == 0 && f == 0) || (i == 1 && f == 1)) ? e : 0, "chain");
        rd_chk(PEND_FLAGS_OFF, ((i == 2 && f == 0) || (i == 3 && f == 1)) ? e : 0, "pend");
        axi_write(CHAIN_CLR_OFF, 32'hFFFF_FFFF);
        axi_write(PEND_CLR_OFF, 32'hFFFF_FFFF);
      end
    end
  endtask : t_flags

  task automatic t_point();
    axi_write(SETTINGS_OFF, 32'h0010_7800);
    pulse(3'b011);
    rd_chk(PEND_FLAGS_OFF, 32'h0000_0000, "early moved");
    pulse(3'b101);
    rd_chk(PEND_FLAGS_OFF, 32'h0000_0080, "early submit");
    axi_write(PEND_CLR_OFF, 32'h0000_0080);
    axi_write(SETTINGS_OFF, 32'h0010_7000);
    pulse(3'b101);
    rd_chk(PEND_FLAGS_OFF, 32'h0000_0000, "normal submit");
  endtask : t_point

  // Reserved code sets no flag at all
  task automatic t_rsvd_code();
    axi_write(SETTINGS_OFF, 32'h00F2_0000);
    pulse(3'b010);
    pulse(3'b011);
    rd_chk(CHAIN_FLAGS_OFF, 32'h0000_0000, "rsvd chain");
    rd_chk(PEND_FLAGS_OFF, 32'h0000_0000, "rsvd pend");
    rd_chk(STATUS_OFF, 32'h0000_0001, "rsvd status");
    axi_write(STATUS_OFF, 32'h0000_0001);
  endtask : t_rsvd_code

  // Neighbouring enable must not pass the pending bit through
  task automatic t_irq();
    axi_write(SETTINGS_OFF, 32'h0010_5000);
    pulse(3'b011);
    axi_write(IRQ_EN_OFF, 32'h0000_0010);
    repeat (2) @(posedge aclk);
    check_word("irq masked", 32'h0, {31'h0, irq});
    axi_write(IRQ_EN_OFF, 32'h0000_0020);
    repeat (2) @(posedge aclk);
    check_word("irq on", 32'h1, {31'h0, irq});
    axi_write(PEND_CLR_OFF, 32'h0000_0020);
    repeat (2) @(posedge aclk);
    check_word("irq off", 32'h0, {31'h0, irq});
  endtask : t_irq

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence after a 12-cycle reset
  initial begin
    {aresetn, awv, wv, br, arv, rr, dw} = '0;
    {awa, ara, wd, dwp, ev} = '0;
    ws = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_settings();
    t_priv();
    t_flags();
    t_point();
    t_rsvd_code();
    t_irq();
    tally_and_finish();
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end
endmodule : dma_completion_signaling_test
`default_nettype wire
